// *** hw/slrc_regs.vh ***
`ifndef SLRC_REGS_VH
`define SLRC_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define SLRC_OFS_CTRL        4'h0
`define SLRC_OFS_PMA_CFG     4'h4
`define SLRC_OFS_STATUS      4'h8

// Control register fields.
`define SLRC_CTRL_MODE_LSB   0
`define SLRC_CTRL_MODE_W     3
`define SLRC_CTRL_RESET      3'h0

// Analogue attachment configuration vector.
`define SLRC_PMA_CFG_W       16
`define SLRC_PMA_CFG_RESET   16'h0000

// Status register bit positions.
`define SLRC_ST_TX_READY     0
`define SLRC_ST_RX_READY     1
`define SLRC_ST_SLEEP        2
`define SLRC_ST_INHIBIT      3
`define SLRC_ST_PCS_RESET    4
`define SLRC_ST_MODE_LSB     8

// Loopback select codes.
`define SLRC_MODE_NORMAL     3'h0
`define SLRC_MODE_SER_PRE    3'h1
`define SLRC_MODE_SER_POST   3'h2
`define SLRC_MODE_PARALLEL   3'h3
`define SLRC_MODE_REPEAT     3'h4

// Clocks the coding sublayer needs to leave reset.
`define SLRC_PCS_RELEASE_CLKS 3'h5

// Path buffer pointer values after a re-centre.
`define SLRC_BUF_WR_CENTRE   2'h2
`define SLRC_BUF_RD_CENTRE   2'h0

// AXI responses.
`define SLRC_RESP_OKAY       2'h0
`define SLRC_RESP_SLVERR     2'h2

`endif

// *** hw/slrc_rst_seq.v ***
`timescale 1ns/100ps
`include "slrc_regs.vh"

module slrc_rst_seq
(
	// Clock and bus reset
	input  wire aclk,
	input  wire aresetn,
	// Path reset from user logic, active high
	input  wire path_reset,
	// High while the path's coding sublayer is held in reset
	output wire in_reset
);

	reg [2:0] cnt_reg;
	reg [2:0] cnt_next;

	// The counter reloads while the reset is high and then runs down over the release clocks.
	always @*
	begin
		cnt_next = cnt_reg;
		if (path_reset)
			cnt_next = `SLRC_PCS_RELEASE_CLKS;
		else if (cnt_reg != 3'h0)
			cnt_next = cnt_reg - 3'h1;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			cnt_reg <= `SLRC_PCS_RELEASE_CLKS;
		else
			cnt_reg <= cnt_next;
	end

	assign in_reset = (cnt_reg != 3'h0);

endmodule // slrc_rst_seq

// *** hw/slrc_top.v ***
`timescale 1ns/100ps
`include "slrc_regs.vh"

module slrc_top
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// User logic controls, same clock
	input  wire        tx_path_reset,
	input  wire        rx_path_reset,
	input  wire        tx_line_inhibit,
	input  wire        xcvr_sleep,
	// User logic data, one bit per clock
	input  wire        tx_bit,
	output wire        rx_bit,
	output wire        rx_bit_valid,
	// Serial line
	input  wire        serial_in_pos,
	output wire        serial_out_pos,
	output wire        serial_out_neg,
	output wire        serial_out_oe,
	// Analogue attachment configuration
	output wire [15:0] pma_cfg
);

	// Loopback select decode, used by the receive path, the line drivers and the status readout.
	function [4:0] slrc_mode_onehot;
		input [2:0] mode;
		case (mode)
			`SLRC_MODE_SER_PRE:  slrc_mode_onehot = 5'h02;
			`SLRC_MODE_SER_POST: slrc_mode_onehot = 5'h04;
			`SLRC_MODE_PARALLEL: slrc_mode_onehot = 5'h08;
			`SLRC_MODE_REPEAT:   slrc_mode_onehot = 5'h10;
			default:             slrc_mode_onehot = 5'h01;
		endcase
	endfunction
	// Register file.
	reg  [2:0]  mode_reg;
	reg  [15:0] pma_cfg_reg;
	// AXI slave state.
	reg         aw_held_reg;
	reg  [3:0]  aw_addr_reg;
	reg         w_held_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         bvalid_reg;
	reg  [1:0]  bresp_reg;
	reg         rvalid_reg;
	reg  [31:0] rdata_reg;
	reg  [1:0]  rresp_reg;
	// Line input synchroniser and filtered level.
	reg         line_s1_reg;
	reg         line_s2_reg;
	reg         line_s3_reg;
	reg         line_level_reg;
	// Transmit path.
	reg  [3:0]  tx_buf_reg;
	reg  [1:0]  tx_wr_reg;
	reg  [1:0]  tx_rd_reg;
	reg         tx_buf_out_reg;
	reg         enc_reg;
	// Receive path.
	reg  [3:0]  rx_buf_reg;
	reg  [1:0]  rx_wr_reg;
	reg  [1:0]  rx_rd_reg;
	reg         dec_prev_reg;
	reg         rx_bit_reg;
	reg         rx_bit_valid_reg;
	// Analogue attachment pipeline and line drivers.
	reg         pma_stage_reg;
	reg         out_pos_reg;
	reg         out_neg_reg;
	reg         out_oe_reg;
	wire        tx_in_reset;
	wire        rx_in_reset;
	wire [4:0]  mode_sel;
	wire        lb_pre;
	wire        lb_post;
	wire        lb_par;
	wire        lb_rep;
	wire        tx_run;
	wire        rx_run;
	wire        rx_line_src;
	wire        rx_buf_in;
	wire        wr_fire;
	wire        ar_fire;
	wire        aw_ok;
	wire        ar_ok;
	reg  [31:0] rd_word;
	slrc_rst_seq u_tx_rst
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.path_reset (tx_path_reset),
		.in_reset   (tx_in_reset)
	);
	slrc_rst_seq u_rx_rst
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.path_reset (rx_path_reset),
		.in_reset   (rx_in_reset)
	);
	// Exactly one mode is active; unused codes fall back to normal operation.
	assign mode_sel = slrc_mode_onehot(mode_reg);
	assign lb_pre   = mode_sel[1];
	assign lb_post  = mode_sel[2];
	assign lb_par   = mode_sel[3];
	assign lb_rep   = mode_sel[4];

	// Besides the path resets, only the dedicated sleep input stops the paths; there is no other power control.
	assign tx_run = !tx_in_reset && !xcvr_sleep;
	assign rx_run = !rx_in_reset && !xcvr_sleep;

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign ar_fire = s_axi_arvalid && !rvalid_reg;
	assign aw_ok   = (aw_addr_reg == `SLRC_OFS_CTRL) || (aw_addr_reg == `SLRC_OFS_PMA_CFG)
		|| (aw_addr_reg == `SLRC_OFS_STATUS);
	assign ar_ok   = (s_axi_araddr == `SLRC_OFS_CTRL) || (s_axi_araddr == `SLRC_OFS_PMA_CFG)
		|| (s_axi_araddr == `SLRC_OFS_STATUS);
	always @*
	begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`SLRC_OFS_CTRL:
				rd_word[`SLRC_CTRL_MODE_LSB +: `SLRC_CTRL_MODE_W] = mode_reg;
			`SLRC_OFS_PMA_CFG:
				rd_word[`SLRC_PMA_CFG_W-1:0] = pma_cfg_reg;
			`SLRC_OFS_STATUS:
			begin
				rd_word[`SLRC_ST_TX_READY]  = !tx_in_reset;
				rd_word[`SLRC_ST_RX_READY]  = !rx_in_reset;
				rd_word[`SLRC_ST_SLEEP]     = xcvr_sleep;
				rd_word[`SLRC_ST_INHIBIT]   = tx_line_inhibit;
				rd_word[`SLRC_ST_PCS_RESET] = tx_in_reset || rx_in_reset;
				rd_word[`SLRC_ST_MODE_LSB +: 5] = mode_sel;
			end
			default:
				rd_word = 32'h0000_0000;
		endcase
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `SLRC_RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `SLRC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_reg)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
			end
			else if (wr_fire)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && !w_held_reg)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held_reg <= 1'b0;
			if (wr_fire)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= aw_ok ? `SLRC_RESP_OKAY : `SLRC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (ar_fire)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_word;
				rresp_reg  <= ar_ok ? `SLRC_RESP_OKAY : `SLRC_RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end
	// Software registers are cleared by the bus reset only, never by a path reset.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_reg    <= `SLRC_CTRL_RESET;
			pma_cfg_reg <= `SLRC_PMA_CFG_RESET;
		end
		else if (wr_fire)
		begin
			if (aw_addr_reg == `SLRC_OFS_CTRL && w_strb_reg[0])
				mode_reg <= w_data_reg[`SLRC_CTRL_MODE_LSB +: `SLRC_CTRL_MODE_W];
			if (aw_addr_reg == `SLRC_OFS_PMA_CFG)
			begin
				if (w_strb_reg[0])
					pma_cfg_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					pma_cfg_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end
	assign pma_cfg = pma_cfg_reg;

	// The line input passes three flops, and a new level counts once the last two agree.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_s1_reg    <= 1'b0;
			line_s2_reg    <= 1'b0;
			line_s3_reg    <= 1'b0;
			line_level_reg <= 1'b0;
		end
		else
		begin
			line_s1_reg <= serial_in_pos;
			line_s2_reg <= line_s1_reg;
			line_s3_reg <= line_s2_reg;
			if (line_s2_reg == line_s3_reg)
				line_level_reg <= line_s3_reg;
		end
	end

	// The transmit path is a small buffer that feeds a transition encoder.
	always @(posedge aclk)
	begin
		if (!aresetn || tx_in_reset)
		begin
			tx_buf_reg     <= 4'h0;
			tx_wr_reg      <= `SLRC_BUF_WR_CENTRE;
			tx_rd_reg      <= `SLRC_BUF_RD_CENTRE;
			tx_buf_out_reg <= 1'b0;
			enc_reg        <= 1'b0;
		end
		else if (tx_run)
		begin
			tx_buf_reg[tx_wr_reg] <= tx_bit;
			tx_wr_reg             <= tx_wr_reg + 2'h1;
			tx_rd_reg             <= tx_rd_reg + 2'h1;
			tx_buf_out_reg        <= tx_buf_reg[tx_rd_reg];
			enc_reg               <= enc_reg ^ tx_buf_out_reg;
		end
	end

	// Pre-driver loop takes the encoder ahead of the driver stage, post-driver
	// takes the driven stage; parallel loop bypasses the serial side entirely.
	assign rx_line_src = lb_pre  ? enc_reg :
		lb_post ? pma_stage_reg :
		line_level_reg;
	assign rx_buf_in   = lb_par ? tx_buf_out_reg : (rx_line_src ^ dec_prev_reg);

	// The receive path is a transition decoder that feeds an elastic buffer.
	always @(posedge aclk)
	begin
		if (!aresetn || rx_in_reset)
		begin
			rx_buf_reg       <= 4'h0;
			rx_wr_reg        <= `SLRC_BUF_WR_CENTRE;
			rx_rd_reg        <= `SLRC_BUF_RD_CENTRE;
			dec_prev_reg     <= 1'b0;
			rx_bit_reg       <= 1'b0;
			rx_bit_valid_reg <= 1'b0;
		end
		else
		begin
			rx_bit_valid_reg <= rx_run;
			if (rx_run)
			begin
				rx_buf_reg[rx_wr_reg] <= rx_buf_in;
				rx_wr_reg             <= rx_wr_reg + 2'h1;
				rx_rd_reg             <= rx_rd_reg + 2'h1;
				dec_prev_reg          <= rx_line_src;
				rx_bit_reg            <= rx_buf_reg[rx_rd_reg];
			end
		end
	end
	assign rx_bit       = rx_bit_reg;
	assign rx_bit_valid = rx_bit_valid_reg;

	// This stage is cleared by the bus reset only, so it keeps moving through path resets.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pma_stage_reg <= 1'b0;
			out_pos_reg   <= 1'b0;
			out_neg_reg   <= 1'b0;
			out_oe_reg    <= 1'b0;
		end
		else
		begin
			pma_stage_reg <= lb_rep ? line_level_reg : enc_reg;
			out_oe_reg    <= !xcvr_sleep && !lb_pre;
			if (tx_line_inhibit || xcvr_sleep || lb_pre)
			begin
				out_pos_reg <= 1'b0;
				out_neg_reg <= 1'b0;
			end
			else
			begin
				out_pos_reg <= pma_stage_reg;
				out_neg_reg <= !pma_stage_reg;
			end
		end
	end
	assign serial_out_pos = out_pos_reg;
	assign serial_out_neg = out_neg_reg;
	assign serial_out_oe  = out_oe_reg;
endmodule // slrc_top

// *** verif/slrc_link_peer.sv ***
`timescale 1ns/100ps
module slrc_link_peer
(
	// Clock
	input  wire  aclk,
	// Level the far end puts on the line
	input  wire  send_level,
	// Line into the block
	output logic serial_in_pos
);
	// The far transmitter only changes its level just after a clock edge.
	initial serial_in_pos = 1'b0;
	always @(posedge aclk)
		serial_in_pos <= send_level;
endmodule // slrc_link_peer

// *** verif/slrc_checker.sv ***
`timescale 1ns/100ps
module slrc_checker
(
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus handshakes
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	// Controls
	input wire        tx_path_reset,
	input wire        rx_path_reset,
	input wire        tx_line_inhibit,
	input wire        xcvr_sleep,
	// Outputs
	input wire        rx_bit_valid,
	input wire        serial_out_pos,
	input wire        serial_out_neg,
	input wire        serial_out_oe,
	input wire [15:0] pma_cfg
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_held;
		!rx_bit_valid [*5];
	endsequence
	sequence s_up;
		##[1:4] rx_bit_valid;
	endsequence
	property p_inhibit;
		tx_line_inhibit |=> !serial_out_pos && !serial_out_neg;
	endproperty
	property p_sleep;
		xcvr_sleep [*2] |=> !serial_out_oe && !rx_bit_valid;
	endproperty
	property p_rxrst;
		rx_path_reset [*2] |=> !rx_bit_valid;
	endproperty
	property p_release;
		$fell(rx_path_reset) && !xcvr_sleep |-> s_held ##0 s_up;
	endproperty
	property p_cfg;
		tx_path_reset || rx_path_reset |=> $stable(pma_cfg) || $rose(s_axi_bvalid);
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_rans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("line high while inhibited");
	a_sleep: assert property (p_sleep) else $error("active while asleep");
	a_rxrst: assert property (p_rxrst) else $error("receive runs in reset");
	a_release: assert property (p_release) else $error("bad reset release time");
	a_cfg: assert property (p_cfg) else $error("config changed by path reset");
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	a_rhold: assert property (p_rhold) else $error("read data not held");
	a_rans: assert property (p_rans) else $error("no read answer");
endmodule // slrc_checker
bind slrc_top slrc_checker u_chk(.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .tx_path_reset, .rx_path_reset,
	.tx_line_inhibit, .xcvr_sleep, .rx_bit_valid, .serial_out_pos, .serial_out_neg, .serial_out_oe, .pma_cfg);

// *** verif/serdes_loopback_reset_ctrl_test.sv ***
`timescale 1ns/100ps
module serdes_loopback_reset_ctrl_test;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, tx_path_reset = 0, rx_path_reset = 0;
	logic        tx_line_inhibit = 0, xcvr_sleep = 0, tx_bit = 0, lvl = 0, rx_prev;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, m;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         rx_bit, rx_bit_valid, serial_in_pos, serial_out_pos, serial_out_neg, serial_out_oe;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  pma_cfg;
	int          fail_count = 0, comparisons = 0, n;
	slrc_top DUT(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_path_reset, .rx_path_reset, .tx_line_inhibit,
		.xcvr_sleep, .tx_bit, .rx_bit, .rx_bit_valid, .serial_in_pos, .serial_out_pos, .serial_out_neg,
		.serial_out_oe, .pma_cfg);
	slrc_link_peer PEER(.aclk, .send_level(lvl), .serial_in_pos);
	initial
	forever
		#4 aclk = ~aclk;
	always @(posedge aclk)
		tx_bit <= ~tx_bit;
	task test_done;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(inout int k);
		@(posedge aclk);
		k++;
		if (k > 60)
		begin
			fail_count++;
			test_done();
		end
	endtask
	task wr(input [3:0] a, input [31:0] d, input [1:0] er);
		int k;
		k = 0;
		tick(k);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		tick(k);
		while (!(s_axi_bvalid && s_axi_bready))
		begin
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			s_axi_bready <= s_axi_bvalid;
			tick(k);
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
		int k;
		k = 0;
		tick(k);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		tick(k);
		while (!(s_axi_rvalid && s_axi_rready))
		begin
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			s_axi_rready <= s_axi_rvalid;
			tick(k);
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h0, 2'h0);
		rd(4'h8, 32'h103, 2'h0);
		rd(4'hC, 32'h0, 2'h2);
		wr(4'hC, 32'h1, 2'h2);
		wr(4'h8, 32'hFFFFFFFF, 2'h0);
		rd(4'h8, 32'h103, 2'h0);
		wr(4'h4, 32'hFFFFA5C3, 2'h0);
		rd(4'h4, 32'hA5C3, 2'h0);
		for (m = 32'h0; m < 32'h5; m++)
		begin
			wr(4'h0, m, 2'h0);
			rd(4'h0, m, 2'h0);
			rd(4'h8, 32'h3 | (32'h100 << m), 2'h0);
			chk(serial_out_oe, m != 32'h1);
			// The alternating transmit bits come back only through the pre-driver, post-driver and parallel loops; the quiet line decodes to zeros.
			rx_prev = rx_bit;
			@(posedge aclk);
			chk(rx_bit != rx_prev, m >= 32'h1 && m <= 32'h3);
		end
		// Repeater mode is left on: the line still echoes while both paths sit in reset.
		tx_path_reset <= 1'b1;
		rx_path_reset <= 1'b1;
		lvl <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({serial_out_pos, serial_out_neg}, 32'h2);
		lvl <= 1'b0;
		rd(4'h8, 32'h1010, 2'h0);
		// The low level needs seven clocks through the peer, the synchroniser and the pipeline.
		repeat (6) @(posedge aclk);
		chk({serial_out_pos, serial_out_neg}, 32'h1);
		chk(pma_cfg, 32'hA5C3);
		rx_path_reset <= 1'b0;
		n = 0;
		@(posedge aclk);
		while (rx_bit_valid !== 1'b1)
			tick(n);
		chk(n >= 5 && n <= 9, 32'h1);
		rd(4'h8, 32'h1012, 2'h0);
		tx_path_reset <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(4'h8, 32'h1003, 2'h0);
		rd(4'h0, 32'h4, 2'h0);
		wr(4'h0, 32'h3, 2'h0);
		tx_line_inhibit <= 1'b1;
		rd(4'h8, 32'h80B, 2'h0);
		chk({serial_out_pos, serial_out_neg, serial_out_oe}, 32'h1);
		tx_line_inhibit <= 1'b0;
		xcvr_sleep <= 1'b1;
		repeat (4) @(posedge aclk);
		chk({serial_out_oe, rx_bit_valid}, 32'h0);
		xcvr_sleep <= 1'b0;
		repeat (12) @(posedge aclk);
		chk({serial_out_oe, rx_bit_valid}, 32'h3);
		test_done();
	end
endmodule // serdes_loopback_reset_ctrl_test
